/* rtl/sisp_defines.vh */
// Constants of the serial in-system programming port: opcodes, answers,
// timing figures and the register map of the control slave.
// Assumes it is included by bare name from the design files below.
//
// Operation
// - Enable instruction must precede all other operations.
// - Chip erase sets every code byte to ffh.
// - Instructions are four bytes; page mode extends.
// - Enable is ac,53; device answers 69 in byte four.
// - Opcode ac with byte two 100x erases array.
// - Erase finishes within 500 ms; programmer waits.
// - Opcode 20 reads addressed byte during byte four.
// - Opcode 40 writes byte four, self-timed write.
// - Lock write ac,111000mm sets protection mode mm.
// - Opcode 24 returns lock bits, programmed reads one.
// - Opcode 30 streams 256 bytes of selected page.
// - Opcode 50 writes 256 bytes into selected page.
// - Page mode: all following bytes are data until 256.
// - Read of byte being written returns inverted msb.
// - Byte write self-timed, 64 clocks plus 400 us.
// - Input sampled on rising edge, output after falling.
// - Reset pin low ends the programming session.
// - Reads during chip erase return 00h.
`ifndef SISP_DEFINES_VH
`define SISP_DEFINES_VH

// Instruction bytes and answers.
`define SISP_OP_SPECIAL    8'hac
`define SISP_ARG_ENABLE    8'h53
`define SISP_ENABLE_ACK    8'h69
`define SISP_ERASE_TAG     3'b100
`define SISP_LOCK_TAG      6'b111000
`define SISP_OP_READ_BYTE  8'h20
`define SISP_OP_WRITE_BYTE 8'h40
`define SISP_OP_READ_LOCK  8'h24
`define SISP_OP_READ_SIG   8'h28
`define SISP_OP_READ_PAGE  8'h30
`define SISP_OP_WRITE_PAGE 8'h50
`define SISP_ERASED        8'hff
`define SISP_BLANK         8'h00
`define SISP_LAST_SHORT    9'd3
`define SISP_LAST_PAGE     9'd257

// Timing figures in their own units and the clock rate.
`define SISP_CLK_MHZ       50
`define SISP_ERASE_MS      500
`define SISP_WRITE_US      400
`define SISP_WRITE_OSC     64

// Control slave register map and reset values.
`define SISP_REG_CTRL      4'h0
`define SISP_REG_STATUS    4'h4
`define SISP_CTRL_RESET    1'b1
`define SISP_RESP_OKAY     2'b00
`define SISP_RESP_DECERR   2'b11

`endif

/* rtl/sisp_code_mem.v */
// Code array of the programming port: single port, synchronous write,
// registered read data.
// Assumes one clock and that address and write strobe come from that domain.
`timescale 1ns/1ns
`default_nettype none

module sisp_code_mem #(
	parameter AW = 13,
	parameter DW = 8
) (
	// Clock.
	input  wire          core_clk,
	// Access port.
	input  wire [AW-1:0] addr,
	input  wire          we,
	input  wire [DW-1:0] wdata,
	output reg  [DW-1:0] rdata
);

	// The array itself; it has no reset, as a real flash has none.
	reg [DW-1:0] mem [0:(1<<AW)-1];

	////////////////////////////////////////////////////////////////////////
	// Read the current address every cycle; a write cycle returns the old content.
	always @(posedge core_clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule // sisp_code_mem
`default_nettype wire

/* rtl/sisp_port.v */
// Serial in-system programming port: decodes instructions shifted in on the
// link, owns the code array, erase and write timers and the lock bits, and
// offers a small AXI4-Lite control slave.
// Assumes link pins arrive asynchronously and are far slower than core_clk.
`timescale 1ns/1ns
`default_nettype none
`include "sisp_defines.vh"

module sisp_port #(
	parameter AW           = 13,
	parameter ERASE_CYCLES = `SISP_ERASE_MS * 1000 * `SISP_CLK_MHZ,
	parameter WRITE_CYCLES = `SISP_WRITE_OSC + `SISP_WRITE_US * `SISP_CLK_MHZ,
	parameter [7:0] SIG0   = 8'h5a, // Arbitrary identity value.
	parameter [7:0] SIG1   = 8'h3c, // Arbitrary identity value.
	parameter [7:0] SIG2   = 8'h01  // Arbitrary identity value.
) (
	// Clock and reset.
	input  wire        core_clk,
	input  wire        rst_n,
	// Programming link pins.
	input  wire        isp_reset_pin,
	input  wire        sck,
	input  wire        mosi,
	output reg         miso,
	output reg         isp_session,
	// AXI4-Lite write channels.
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read channels.
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	// Synchronisers for the three link inputs.
	reg          rst_s1, rst_s2;
	reg          sck_s1, sck_s2, sck_d;
	reg          mosi_s1, mosi_s2;
	// Instruction decoder state.
	reg  [2:0]   bit_cnt;        // Bits of the current byte.
	reg  [8:0]   byte_idx;       // Byte within the instruction.
	reg  [7:0]   rx_shift;       // Incoming bits.
	reg  [7:0]   tx_shift;       // Outgoing bits.
	reg  [7:0]   op;             // First byte.
	reg  [7:0]   arg_byte;       // Second byte.
	reg  [7:0]   page_off;       // Offset inside a page burst.
	reg          enabled;        // Enable instruction accepted.
	reg  [2:0]   locks;          // Protection levels, first in bit 0.
	// Array port and timers.
	reg  [AW-1:0] lnk_addr;
	reg          lnk_we;
	reg  [7:0]   lnk_wdata;
	reg  [AW-1:0] last_addr;     // Target of the latest write.
	reg  [7:0]   last_data;
	reg  [24:0]  erase_cnt;
	reg          sweeping;
	reg  [AW-1:0] erase_addr;
	reg  [14:0]  write_cnt;
	// Control slave.
	reg          link_en;
	reg          aw_held, w_held;
	reg  [3:0]   aw_addr;
	reg  [31:0]  w_data;
	reg  [3:0]   w_strb;

	wire [7:0]    rdata;
	wire          session    = rst_s2 & link_en;
	wire          sck_rise   = sck_s2 & ~sck_d;
	wire          sck_fall   = ~sck_s2 & sck_d;
	wire [7:0]    rx_byte    = {rx_shift[6:0], mosi_s2};
	wire          byte_done  = sck_rise & (bit_cnt == 3'd7);
	wire          is_page    = (op == `SISP_OP_READ_PAGE) | (op == `SISP_OP_WRITE_PAGE);
	wire [8:0]    last_idx   = is_page ? `SISP_LAST_PAGE : `SISP_LAST_SHORT;
	wire          erase_busy = (erase_cnt != 25'd0);
	wire          write_busy = (write_cnt != 15'd0);
	wire          is_enable  = (op == `SISP_OP_SPECIAL) & (arg_byte == `SISP_ARG_ENABLE);
	wire          may_act    = enabled & ~erase_busy;
	wire          may_write  = may_act & ~locks[0];
	wire          may_read   = ~locks[1];
	wire [AW-1:0] mem_addr   = sweeping ? erase_addr : lnk_addr;
	wire          mem_we     = sweeping | (lnk_we & ~erase_busy);
	wire [7:0]    mem_wdata  = sweeping ? `SISP_ERASED : lnk_wdata;

	// Answer byte that the next output byte starts from.
	reg  [7:0]    tx_byte;

	////////////////////////////////////////////////////////////////////////
	// Code array.
	sisp_code_mem #(
		.AW    (AW),
		.DW    (8)
	) u_mem (
		.core_clk (core_clk),
		.addr     (mem_addr),
		.we       (mem_we),
		.wdata    (mem_wdata),
		.rdata    (rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Two flip-flops on every pin before any logic looks at it.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1  <= 1'b0;
			rst_s2  <= 1'b0;
			sck_s1  <= 1'b0;
			sck_s2  <= 1'b0;
			sck_d   <= 1'b0;
			mosi_s1 <= 1'b0;
			mosi_s2 <= 1'b0;
		end else begin
			rst_s1  <= isp_reset_pin;
			rst_s2  <= rst_s1;
			sck_s1  <= sck;
			sck_s2  <= sck_s1;
			sck_d   <= sck_s2;
			mosi_s1 <= mosi;
			mosi_s2 <= mosi_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Answer selection. Reads are blanked while the array is being erased.
	always @* begin
		tx_byte = `SISP_BLANK;
		if (is_enable) begin
			tx_byte = `SISP_ENABLE_ACK;
		end else if (erase_busy || !enabled) begin
			tx_byte = `SISP_BLANK;
		end else begin
			case (op)
				`SISP_OP_READ_BYTE, `SISP_OP_READ_PAGE: begin
					if (!may_read) begin
						tx_byte = `SISP_BLANK;
					end else if (write_busy && lnk_addr == last_addr) begin
						tx_byte = {~last_data[7], rdata[6:0]};
					end else begin
						tx_byte = rdata;
					end
				end
				`SISP_OP_READ_LOCK: tx_byte = {3'b000, locks, 2'b00};
				`SISP_OP_READ_SIG: begin
					case (arg_byte[1:0])
						2'd0:    tx_byte = SIG0;
						2'd1:    tx_byte = SIG1;
						2'd2:    tx_byte = SIG2;
						default: tx_byte = `SISP_BLANK;
					endcase
				end
				default: tx_byte = `SISP_BLANK;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bit and byte framing, instruction execution and array requests.
	// The reset pin low clears framing, opcode, enable and miso, mid-instruction or not.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt   <= 3'd0;
			byte_idx  <= 9'd0;
			rx_shift  <= 8'h00;
			tx_shift  <= 8'h00;
			op        <= 8'h00;
			arg_byte  <= 8'h00;
			page_off  <= 8'h00;
			enabled   <= 1'b0;
			locks     <= 3'b000;
			lnk_addr  <= {AW{1'b0}};
			lnk_we    <= 1'b0;
			lnk_wdata <= 8'h00;
			last_addr <= {AW{1'b0}};
			last_data <= 8'h00;
			miso      <= 1'b0;
			isp_session <= 1'b0;
		end else begin
			lnk_we      <= 1'b0;
			isp_session <= session;
			if (!session) begin
				bit_cnt  <= 3'd0;
				byte_idx <= 9'd0;
				enabled  <= 1'b0;
				op       <= 8'h00;
				arg_byte <= 8'h00;
				miso     <= 1'b0;
			end else begin
				// Output changes only after a falling edge, msb first.
				if (sck_fall) begin
					if (bit_cnt == 3'd0) begin
						miso     <= tx_byte[7];
						tx_shift <= {tx_byte[6:0], 1'b0};
					end else begin
						miso     <= tx_shift[7];
						tx_shift <= {tx_shift[6:0], 1'b0};
					end
				end
				// Input is sampled on the rising edge, msb first.
				if (sck_rise) begin
					rx_shift <= rx_byte;
					bit_cnt  <= bit_cnt + 3'd1;
				end
				if (byte_done) begin
					byte_idx <= (byte_idx == last_idx) ? 9'd0 : byte_idx + 9'd1;
					if (byte_idx == 9'd0) begin
						op <= rx_byte;
					end else if (byte_idx == 9'd1) begin
						arg_byte <= rx_byte;
						page_off <= 8'h00;
						lnk_addr <= {rx_byte[AW-9:0], 8'h00};
					end else if (is_page) begin
						// Every byte after the page number is data.
						page_off <= page_off + 8'd1;
						lnk_addr <= {arg_byte[AW-9:0], page_off + 8'd1};
						if (op == `SISP_OP_WRITE_PAGE && may_write) begin
							lnk_we    <= 1'b1;
							lnk_wdata <= rx_byte;
							lnk_addr  <= {arg_byte[AW-9:0], page_off};
							last_addr <= {arg_byte[AW-9:0], page_off};
							last_data <= rx_byte;
						end
					end else if (byte_idx == 9'd2) begin
						lnk_addr <= {arg_byte[AW-9:0], rx_byte};
					end else begin
						// Fourth byte: the instruction is complete.
						if (is_enable) begin
							enabled <= 1'b1;
						end else if (may_act && op == `SISP_OP_SPECIAL) begin
							if (arg_byte[7:5] == `SISP_ERASE_TAG) begin
								locks <= 3'b000;
							end else if (arg_byte[7:2] == `SISP_LOCK_TAG) begin
								// Each level needs the one below it first.
								case (arg_byte[1:0])
									2'b01:   locks[0] <= 1'b1;
									2'b10:   locks[1] <= locks[0];
									2'b11:   locks[2] <= locks[1];
									default: locks    <= locks;
								endcase
							end
						end else if (may_write && op == `SISP_OP_WRITE_BYTE) begin
							lnk_we    <= 1'b1;
							lnk_wdata <= rx_byte;
							last_addr <= lnk_addr;
							last_data <= rx_byte;
						end
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Erase and write timers. The erase sweep fills the array with ffh in
	// the first cycles of the erase window; the rest is the required wait.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			erase_cnt  <= 25'd0;
			sweeping   <= 1'b0;
			erase_addr <= {AW{1'b0}};
			write_cnt  <= 15'd0;
		end else begin
			if (session && byte_done && !is_page && byte_idx == 9'd3 && may_act &&
				op == `SISP_OP_SPECIAL && arg_byte[7:5] == `SISP_ERASE_TAG) begin
				erase_cnt  <= ERASE_CYCLES[24:0];
				sweeping   <= 1'b1;
				erase_addr <= {AW{1'b0}};
			end else begin
				if (erase_busy) begin
					erase_cnt <= erase_cnt - 25'd1;
				end
				if (sweeping) begin
					erase_addr <= erase_addr + {{(AW-1){1'b0}}, 1'b1};
					if (&erase_addr) begin
						sweeping <= 1'b0;
					end
				end
			end
			if (lnk_we && !erase_busy) begin
				write_cnt <= WRITE_CYCLES[14:0];
			end else if (write_busy) begin
				write_cnt <= write_cnt - 15'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave. Address and data are taken in either order; the
	// response follows once both are held. Unmapped offsets answer DECERR.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SISP_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `SISP_RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			link_en       <= `SISP_CTRL_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				if (aw_addr == `SISP_REG_CTRL) begin
					s_axi_bresp <= `SISP_RESP_OKAY;
					if (w_strb[0]) begin
						link_en <= w_data[0];
					end
				end else if (aw_addr == `SISP_REG_STATUS) begin
					s_axi_bresp <= `SISP_RESP_OKAY;
				end else begin
					s_axi_bresp <= `SISP_RESP_DECERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			// Reads answer one cycle after the address is taken.
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `SISP_RESP_OKAY;
				case (s_axi_araddr)
					`SISP_REG_CTRL:   s_axi_rdata <= {31'd0, link_en};
					`SISP_REG_STATUS: s_axi_rdata <= {25'd0, locks, write_busy, erase_busy, enabled, session};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `SISP_RESP_DECERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // sisp_port
`default_nettype wire

/* bench/sisp_properties.sv */
// Checker of the programming port: bus handshakes and link pin timing.
// Assumes it is bound to sisp_port and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "sisp_defines.vh"

module sisp_properties (
	// Clock and reset.
	input wire logic        core_clk,
	input wire logic        rst_n,
	// Link pins.
	input wire logic        isp_reset_pin,
	input wire logic        sck,
	input wire logic        miso,
	input wire logic        isp_session,
	// Register bus.
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [3:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	// All checks live in the core clock domain.
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// A response stays up until the master takes it.
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read response dropped or changed");
	// No new request is taken while a response is pending.
	property p_w_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_w_block: assert property (p_w_block) else $error("write taken under pending response");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken under pending response");
	// Answers come promptly; unmapped read offsets above 4h decode to an error.
	property p_b_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("write response late");
	property p_r_decerr;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 4'h4
			|-> ##[1:2] (s_axi_rvalid && s_axi_rresp == `SISP_RESP_DECERR && s_axi_rdata == 32'h0);
	endproperty
	a_r_decerr: assert property (p_r_decerr) else $error("unmapped read not refused");

	////////////////////////////////////////////////////////////////////////
	// Serial output moves only in the low phase of the shift clock.
	property p_miso_fall;
		$changed(miso) && isp_reset_pin && $past(isp_reset_pin, 4) |-> !$past(sck, 2);
	endproperty
	a_miso_fall: assert property (p_miso_fall) else $error("serial output moved in high phase");
	// A low reset pin ends the session and quiets the output.
	property p_end;
		!isp_reset_pin [*4] |-> !isp_session && !miso;
	endproperty
	a_end: assert property (p_end) else $error("session outlived the reset pin");
	property p_sess_rise;
		$rose(isp_session) |-> $past(isp_reset_pin, 2);
	endproperty
	a_sess_rise: assert property (p_sess_rise) else $error("session opened with pin low");
endmodule // sisp_properties

bind sisp_port sisp_properties u_props (
	.core_clk(core_clk), .rst_n(rst_n), .isp_reset_pin(isp_reset_pin), .sck(sck), .miso(miso),
	.isp_session(isp_session), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

/* bench/sisp_prog_model.sv */
// Model of the external programmer that drives the serial link.
// Assumes a 50 MHz device clock; the shift clock is timed by delays only.
`timescale 1ns/1ns
`default_nettype none

module sisp_prog_model (
	// Link pins.
	output var logic isp_reset_pin,
	output var logic sck,
	output var logic mosi,
	input  wire logic miso
);
	// Each phase spans more than eight device clocks; pins move 5 ns off
	// every device clock edge, so no change lands in an edge's time step.
	localparam int HALF_NS = 170;

	// The link starts idle with the shift clock parked low.
	initial begin
		isp_reset_pin = 1'b0;
		sck = 1'b0;
		mosi = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Moves the reset pin, then keeps the clock low for 69 device clocks.
	task automatic session(input logic on);
		align();
		sck = 1'b0;
		isp_reset_pin = on;
		#(64 * 20 + 100);
	endtask

	// Moves the caller to 5 ns past a multiple of the 20 ns clock period.
	task automatic align();
		#((25 - $time % 20) % 20);
	endtask

	// Shifts one byte msb first; data is set in the low phase and the
	// answer is taken just before the rising edge.
	task automatic xfer(input logic [7:0] b, output logic [7:0] r);
		int i;
		align();
		for (i = 7; i >= 0; i--) begin
			mosi = b[i];
			#(HALF_NS);
			r[i] = miso;
			sck = 1'b1;
			#(HALF_NS);
			sck = 1'b0;
		end
		// A released line shows the inverse of its last bit.
		mosi = ~b[0];
	endtask

	// Sends one four-byte instruction; the answer is the fourth byte's.
	task automatic instr(input logic [7:0] v0, v1, v2, v3, output logic [7:0] r);
		logic [7:0] j;
		xfer(v0, j);
		xfer(v1, j);
		xfer(v2, j);
		xfer(v3, r);
	endtask
endmodule // sisp_prog_model
`default_nettype wire

/* bench/tb_top.sv */
// Testbench of the programming port: bus tasks, a byte model of the array and link scenarios.
// Assumes the link model and the bound checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "sisp_defines.vh"

module tb_top;
	localparam int WRC = 800;  // Shortened byte write time.
	localparam int ERC = 9000; // Shortened erase time, above the sweep.
	logic        core_clk, rst_n, aw_v, w_v, b_r, ar_v, r_r;
	logic [3:0]  aw_a, ar_a;
	logic [31:0] w_d, w;
	logic [1:0]  rs;
	wire logic   aw_r, w_r, b_v, ar_r, r_v, pin, sck, mosi, miso, sess;
	wire logic [1:0]  b_rs, r_rs;
	wire logic [31:0] r_d;
	logic [7:0]  mem [0:8191]; // Expected array content.
	logic [7:0]  r, d8;
	logic [31:0] seed;
	logic [12:0] a;
	logic [4:0]  pg;
	int          num_errors, samples_checked, i, m, lk;

	sisp_port #(.ERASE_CYCLES(ERC), .WRITE_CYCLES(WRC), .SIG1(8'ha7)) DUT (.core_clk(core_clk), .rst_n(rst_n),
		.isp_reset_pin(pin), .sck(sck), .mosi(mosi), .miso(miso), .isp_session(sess),
		.s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_rs),
		.s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
		.s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v),
		.s_axi_rready(r_r));
	sisp_prog_model prog (.isp_reset_pin(pin), .sck(sck), .mosi(mosi), .miso(miso));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////
	// Random numbers, comparisons and the verdict.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic hang();
		num_errors++;
		$display("unexpected bus_wait expected answer seen none");
		close_out();
	endtask
	task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] s);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Bus cycles: each channel is released at its own handshake.
	task automatic wr(input logic [3:0] ad, input logic [31:0] d, output logic [1:0] br);
		int n;
		n = 0;
		@(posedge core_clk);
		aw_a <= ad;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		do begin
			@(posedge core_clk);
			if (aw_r) aw_v <= 1'b0;
			if (w_r) w_v <= 1'b0;
			if (++n > 50) hang();
		end while (!b_v);
		br = b_rs;
		b_r <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] ad, output logic [31:0] d, output logic [1:0] rr);
		int n;
		n = 0;
		@(posedge core_clk);
		ar_a <= ad;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		do begin
			@(posedge core_clk);
			if (ar_r) ar_v <= 1'b0;
			if (++n > 50) hang();
		end while (!r_v);
		d = r_d;
		rr = r_rs;
		r_r <= 1'b0;
	endtask
	// Byte mode link accesses; the address splits over bytes two and three.
	task automatic lrd(input logic [12:0] ad, output logic [7:0] v);
		prog.instr(8'h20, {3'h0, ad[12:8]}, ad[7:0], 8'(rnd()), v);
	endtask
	task automatic lwr(input logic [12:0] ad, input logic [7:0] v);
		logic [7:0] j;
		prog.instr(8'h40, {3'h0, ad[12:8]}, ad[7:0], v, j);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		{rst_n, aw_v, w_v, b_r, ar_v, r_r, aw_a, ar_a, w_d} = '0;
		seed = 32'hbb195fbb;
		num_errors = 0;
		samples_checked = 0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(`SISP_REG_CTRL, w, rs);
		cmp32("ctrl", 32'h1, w);
		rd(4'h8, w, rs);
		cmp32("rresp", 32'h3, {30'h0, rs});
		wr(4'hc, 32'h0, rs);
		cmp32("bresp", 32'h3, {30'h0, rs});
		$display("test registers done");
		prog.session(1'b1);
		lrd(13'h0, r);
		cmp8("before_enable", 8'h00, r);
		prog.instr(8'hac, 8'h53, 8'(rnd()), 8'(rnd()), r);
		cmp8("enable_ack", 8'h69, r);
		prog.instr(8'h28, 8'h01, 8'h00, 8'(rnd()), r);
		cmp8("signature", 8'ha7, r);
		a = 13'(rnd());
		d8 = 8'(rnd());
		mem[a] = d8;
		lwr(a, d8);
		lrd(a, r);
		cmp8("poll_msb", {~d8[7], 7'h0}, r & 8'h80);
		repeat (WRC + 100) @(posedge core_clk);
		rd(`SISP_REG_STATUS, w, rs);
		cmp32("write_busy", 32'h0, w & 32'h8);
		prog.instr(8'h77, 8'(rnd()), 8'(rnd()), 8'(rnd()), r);
		lrd(a, r);
		cmp8("byte_read", mem[a], r);
		$display("test byte mode done");
		pg = a[12:8] ^ 5'h10;
		prog.xfer(8'h50, r);
		prog.xfer({3'h0, pg}, r);
		for (i = 0; i < 256; i++) begin
			mem[{pg, i[7:0]}] = 8'(rnd());
			prog.xfer(mem[{pg, i[7:0]}], r);
		end
		repeat (WRC + 100) @(posedge core_clk);
		prog.xfer(8'h30, r);
		prog.xfer({3'h0, pg}, r);
		for (i = 0; i < 256; i++) begin
			prog.xfer(8'(rnd()), r);
			cmp8("page_read", mem[{pg, i[7:0]}], r);
		end
		lrd({pg, 8'hff}, r);
		cmp8("after_page", mem[{pg, 8'hff}], r);
		$display("test page mode done");
		for (m = 1; m < 4; m++) begin
			prog.instr(8'hac, {6'b111000, m[1:0]}, 8'(rnd()), 8'(rnd()), r);
			prog.instr(8'h24, 8'(rnd()), 8'(rnd()), 8'(rnd()), r);
			lk = ((1 << m) - 1) << 2;
			cmp8("lock_bits", lk[7:0], r & 8'h1c);
			if (m == 1) begin
				lwr(a, ~mem[a]);
				repeat (WRC + 100) @(posedge core_clk);
				lrd(a, r);
				cmp8("locked_write", mem[a], r);
			end
			if (m == 2) begin
				lrd(a, r);
				cmp8("locked_read", 8'h00, r);
			end
		end
		$display("test locks done");
		prog.instr(8'hac, {3'b100, 5'(rnd())}, 8'(rnd()), 8'(rnd()), r);
		lrd(a, r);
		cmp8("erase_read", 8'h00, r);
		repeat (ERC + 100) @(posedge core_clk);
		for (i = 0; i < 4; i++) begin
			lrd(13'(rnd()), r);
			cmp8("erased", 8'hff, r);
		end
		d8 = 8'(rnd());
		lwr(a, d8);
		repeat (WRC + 100) @(posedge core_clk);
		lrd(a, r);
		cmp8("rewrite", d8, r);
		$display("test erase done");
		prog.session(1'b0);
		cmp8("session_end", 8'h00, {7'h0, sess});
		prog.session(1'b1);
		lrd(a, r);
		cmp8("enable_again", 8'h00, r);
		wr(`SISP_REG_CTRL, 32'h0, rs);
		rd(`SISP_REG_STATUS, w, rs);
		cmp32("link_off", 32'h0, w & 32'h3);
		wr(`SISP_REG_CTRL, 32'h1, rs);
		rd(`SISP_REG_STATUS, w, rs);
		cmp32("link_on", 32'h1, w & 32'h3);
		$display("test session done");
		close_out();
	end
endmodule // tb_top
`default_nettype wire
